// ==== dv/adcrs_core_model.sv ====
// Behavioural conversion core: timed conversions and injected ends
`timescale 1ns/1ns
module adcrs_core_model
    import adcrs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       conv_start,
    input  wire logic [2:0] conv_chan,
    input  wire logic       inj,
    input  wire logic [2:0] inj_chan,
    input  wire logic [9:0] inj_data,
    output adcrs_eoc_t      eoc
);
    logic [3:0] cnt;
    logic [2:0] ch;
    // Data toggles every cycle except on an injected end so a stale value is never mistaken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            ch  <= 3'h0;
            eoc <= '0;
        end else begin
            cnt      <= conv_start ? 4'h6 : cnt - {3'h0, cnt != 4'h0};
            ch       <= conv_start ? conv_chan : ch;
            eoc.done <= inj | cnt == 4'h1;
            eoc.chan <= inj ? inj_chan : ch;
            eoc.data <= inj ? inj_data : ~eoc.data;
        end
    end
endmodule : adcrs_core_model

// ==== dv/adcrs_flags_sva.sv ====
// Port-level checker of the converter result and status flag block
`timescale 1ns/1ns
module adcrs_flags_sva
    import adcrs_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire adcrs_eoc_t  eoc_in,
    input wire logic        conv_start,
    input wire logic        conv_sleep
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] en, eoc, ovr, late;
    logic       rdy, govr, kept;
    logic [2:0] lch;
    logic [9:0] ldat;
    logic [9:0] cdat [8];
    // Accesses take effect at the edge where waitrequest is low
    wire        rd   = avs_read & ~avs_waitrequest;
    wire        wr   = avs_write & ~avs_waitrequest;
    wire        st   = rd && avs_address == OFS_STATUS;
    wire        lat  = rd && avs_address == OFS_LATEST;
    wire [7:0]  ofs  = avs_address - OFS_CHAN0;
    wire        chr  = rd && ofs < 8'h20 && ofs[1:0] == 2'h0;
    wire [2:0]  c    = eoc_in.chan;
    wire        set  = eoc_in.done & en[c];
    wire [7:0]  setv = set ? 8'h01 << c : 8'h00;
    wire        latc = lat & ~kept;
    wire [7:0]  clr  = (chr ? 8'h01 << ofs[4:2] : 8'h00) & ~late
                     | (latc ? 8'h01 << lch : 8'h00);
    // Shadow flags; a set beats a clear, a set after the snapshot survives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en   <= 8'h00;
            eoc  <= 8'h00;
            ovr  <= 8'h00;
            rdy  <= 1'b0;
            govr <= 1'b0;
            late <= 8'h00;
            kept <= 1'b0;
            lch  <= 3'h0;
            ldat <= 10'h000;
            for (int i = 0; i < 8; i++) cdat[i] <= 10'h000;
        end else begin
            if (wr && avs_address == OFS_CH_ENA) en <= en | avs_writedata[7:0];
            if (wr && avs_address == OFS_CH_DIS) en <= en & ~avs_writedata[7:0];
            eoc  <= eoc & ~clr | setv;
            late <= setv;
            kept <= set;
            ovr  <= setv & eoc & ~clr | ovr & ~(st ? avs_readdata[15:8] : 8'h00);
            rdy  <= set | rdy & ~latc;
            govr <= set & rdy | govr & ~(st & avs_readdata[BIT_GOVR]);
            if (set) begin
                lch     <= c;
                ldat    <= eoc_in.data;
                cdat[c] <= eoc_in.data;
            end
        end
    end
    rdy_status_a: assert property (st |->
        avs_readdata[BIT_RDY] == $past(rdy)) else $error("ready flag wrong");
    govr_status_a: assert property (st |->
        avs_readdata[BIT_GOVR] == $past(govr)) else $error("global overrun wrong");
    eoc_status_a: assert property (st |->
        avs_readdata[7:0] == $past(eoc)) else $error("completion flags wrong");
    ovr_status_a: assert property (st |->
        avs_readdata[15:8] == $past(ovr)) else $error("channel overrun wrong");
    latest_data_a: assert property (lat |->
        avs_readdata[12:0] == {$past(lch), $past(ldat)}) else $error("latest result wrong");
    chan_data_a: assert property (chr |->
        avs_readdata[9:0] == $past(cdat[ofs[4:2]])) else $error("channel result wrong");
    sleep_late_a: assert property ($rose(conv_sleep) |->
        $past(eoc_in.done) || $past(eoc_in.done, 2) || $past(eoc_in.done, 3))
        else $error("sleep without a conversion");
    one_wait_a: assert property ($rose(avs_read | avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest) else $error("wait count wrong");
    start_pulse_a: assert property (conv_start |=> !conv_start) else $error("start too long");
    cover property (st && avs_readdata[BIT_GOVR]);
    cover property (lat && eoc_in.done);
    cover property ($rose(conv_sleep));
endmodule : adcrs_flags_sva
bind adcrs_flags adcrs_flags_sva u_sva (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .eoc_in(eoc_in),
    .conv_start(conv_start), .conv_sleep(conv_sleep));

// ==== dv/adcrs_flags_tb.sv ====
// Self-checking bench of the converter result and status flag block
`timescale 1ns/1ns
module adcrs_flags_tb import adcrs_pkg::*; ();
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rq;
    logic        avs_waitrequest, conv_start, conv_sleep, irq;
    logic [2:0]  conv_chan;
    adcrs_eoc_t  eoc_in;
    logic        inj = 1'b0;
    logic [2:0]  inj_chan = 3'h0;
    logic [9:0]  inj_data = 10'h000;
    int          fail_count = 0;
    int          checks_done = 0;
    int          cyc = 0;
    adcrs_flags u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .eoc_in(eoc_in),
        .conv_start(conv_start), .conv_chan(conv_chan), .conv_sleep(conv_sleep), .irq(irq));
    adcrs_core_model u_core (.clk(clk), .rst_n(rst_n), .conv_start(conv_start),
        .conv_chan(conv_chan), .inj(inj), .inj_chan(inj_chan), .inj_data(inj_data),
        .eoc(eoc_in));
    always #20 clk = ~clk;
    // Cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !w;
        avs_write     <= w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rq = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    // One end of conversion reported by the core
    task automatic ev(input logic [2:0] c, input logic [9:0] d);
        @(posedge clk);
        inj      <= 1'b1;
        inj_chan <= c;
        inj_data <= d;
        @(posedge clk);
        inj <= 1'b0;
    endtask : ev
    function automatic logic [31:0] st(input logic [7:0] e, o, input logic r, g);
        return {14'h0, g, r, o, e};
    endfunction : st
    initial begin
        int k;
        void'($urandom(60));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_STATUS);
        chk("status", rq, 32'h0);
        rd(OFS_ID);
        chk("id", rq, ID_VALUE);
        rd(8'hfc);
        chk("unmapped", rq, 32'h0);
        $display("reset test done");
        wr(OFS_CH_ENA, 32'hf);
        ev(3'h1, 10'h2a5);
        rd(OFS_STATUS);
        chk("status", rq, st(8'h02, 8'h00, 1'b1, 1'b0));
        rd(OFS_CHAN0);
        rd(OFS_STATUS);
        chk("status", rq, st(8'h02, 8'h00, 1'b1, 1'b0));
        rd(OFS_CHAN0 + 8'h04);
        chk("chan1", rq, 32'h2a5);
        rd(OFS_STATUS);
        chk("status", rq, st(8'h00, 8'h00, 1'b1, 1'b0));
        rd(OFS_LATEST);
        chk("latest", rq, {19'h0, 3'h1, 10'h2a5});
        rd(OFS_STATUS);
        chk("status", rq, 32'h0);
        ev(3'h2, 10'h111);
        ev(3'h2, 10'h0ee);
        rd(OFS_STATUS);
        chk("status", rq, st(8'h04, 8'h04, 1'b1, 1'b1));
        rd(OFS_STATUS);
        chk("status", rq, st(8'h04, 8'h00, 1'b1, 1'b0));
        rd(OFS_LATEST);
        wr(OFS_CH_DIS, 32'h8);
        ev(3'h3, 10'h3c3);
        rd(OFS_STATUS);
        chk("status", rq, 32'h0);
        rd(OFS_LATEST);
        chk("latest", rq, {19'h0, 3'h2, 10'h0ee});
        $display("flag test done");
        wr(OFS_EVENT, 32'h7);
        wr(OFS_IRQ_ENA, 32'h1);
        ev(3'h0, 10'h001);
        repeat (4) @(posedge clk);
        chk("irq", irq, 1'b1);
        rd(OFS_EVENT);
        chk("event", rq, 32'h1);
        wr(OFS_IRQ_ENA, 32'h0);
        repeat (4) @(posedge clk);
        chk("irq", irq, 1'b0);
        wr(OFS_IRQ_ENA, 32'h1);
        repeat (4) @(posedge clk);
        chk("irq", irq, 1'b1);
        wr(OFS_EVENT, 32'h1);
        repeat (4) @(posedge clk);
        chk("irq", irq, 1'b0);
        $display("interrupt test done");
        // Sleep chosen while idle must wait for a conversion to end
        wr(OFS_MODE, 32'h1);
        rd(OFS_MODE);
        chk("mode", rq, 32'h1);
        repeat (10) @(posedge clk);
        chk("sleep", conv_sleep, 1'b0);
        wr(OFS_CONTROL, 32'h1);
        for (int i = 0; i < 40 && conv_sleep !== 1'b1; i++) @(posedge clk);
        chk("sleep", conv_sleep, 1'b1);
        rd(OFS_STATUS);
        chk("sleeping", rq[BIT_SLEEPING], 1'b1);
        wr(OFS_MODE, 32'h0);
        repeat (4) @(posedge clk);
        chk("sleep", conv_sleep, 1'b0);
        // Lowest enabled channel is offered to the core
        wr(OFS_CH_DIS, 32'h3);
        rd(OFS_CH_STAT);
        chk("enables", rq, 32'h4);
        chk("chan", conv_chan, 3'h2);
        $display("sleep test done");
        // Random accesses racing core ends; the checker judges each read
        for (int i = 0; i < 300; i++) begin
            k = $urandom % 6;
            fork
                case (k)
                    0: rd(OFS_STATUS);
                    1: rd(OFS_LATEST);
                    2, 3: rd(OFS_CHAN0 + {3'h0, 3'($urandom), 2'h0});
                    4: wr(OFS_CH_ENA, $urandom);
                    default: wr(OFS_CH_DIS, 32'h1 << $urandom % 8);
                endcase
                begin
                    repeat ($urandom % 4) @(posedge clk);
                    ev(3'($urandom), 10'($urandom));
                end
            join
        end
        rd(OFS_ID);
        chk("id", rq, ID_VALUE);
        $display("random test done");
        end_of_test();
    end
endmodule : adcrs_flags_tb

// ==== inc/adcrs_pkg.sv ====
// Package for the converter result and status flag block
package adcrs_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL  = 8'h00;  // Start command
    localparam logic [7:0] OFS_MODE     = 8'h04;  // Sleep option
    localparam logic [7:0] OFS_CH_ENA   = 8'h10;  // Channel enable set
    localparam logic [7:0] OFS_CH_DIS   = 8'h14;  // Channel enable clear
    localparam logic [7:0] OFS_CH_STAT  = 8'h18;  // Channel enable state
    localparam logic [7:0] OFS_STATUS   = 8'h1c;  // Flag status
    localparam logic [7:0] OFS_LATEST   = 8'h20;  // Last converted result
    localparam logic [7:0] OFS_IRQ_ENA  = 8'h24;  // Interrupt mask
    localparam logic [7:0] OFS_EVENT    = 8'h28;  // Sticky events, write one to clear
    localparam logic [7:0] OFS_ID       = 8'h2c;  // Block identity
    localparam logic [7:0] OFS_CHAN0    = 8'h30;  // First channel result

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_START       = 0;
    localparam int BIT_SLEEP       = 0;
    localparam int POS_EOC         = 0;   // Completion flags, one per channel
    localparam int POS_OVR         = 8;   // Channel overrun flags
    localparam int BIT_RDY         = 16;
    localparam int BIT_GOVR        = 17;
    localparam int BIT_SLEEPING    = 18;
    localparam int EV_RDY          = 0;   // Event bit: result ready
    localparam int EV_GOVR         = 1;   // Event bit: global overrun
    localparam int EV_OVR          = 2;   // Event bit: any channel overrun
    localparam int NUM_EVENTS      = 3;
    localparam logic [31:0] ID_VALUE = 32'h0a5c_0001;  // Arbitrary value

    // Converter activity
    typedef enum logic [2:0] {
        ADCRS_IDLE  = 3'b001,
        ADCRS_BUSY  = 3'b010,
        ADCRS_SLEEP = 3'b100
    } adcrs_state_t;

    // End-of-conversion report from the core
    typedef struct packed {
        logic       done;
        logic [2:0] chan;
        logic [9:0] data;
    } adcrs_eoc_t;

endpackage : adcrs_pkg

// ==== verilog/adcrs_flags.sv ====
// Result store and status flags of the converter controller
//
// Summary of operation
// RULE1 - Only a read of the latest result register clears the result ready flag.
// RULE2 - A channel result read never touches the result ready flag, only its own completion flag.
// RULE3 - An end of conversion on an enabled channel stores both results and raises ready, whatever other channels do.
// RULE4 - A conversion on a disabled channel stores nothing and never raises ready.
// RULE5 - An end of conversion while ready is set raises global overrun even during a status read.
// RULE6 - A status read clears global overrun unless a new overrun arrives in that cycle.
// RULE7 - An end of conversion with the channel completion flag set raises its overrun; disables elsewhere change nothing.
// Code: not raised when a channel or latest result read clears that flag in the same cycle.
// RULE8 - A channel result read or a latest result read clears that channel completion flag.
// RULE9 - A status read clears channel overrun even when that channel completes in the same cycle. Code: an overrunning completion keeps it set.
// RULE10 - A channel disabled during its conversion never gets its completion flag.
// RULE11 - A channel result read clears only that channel completion flag.
// RULE12 - A channel result read beside another channel's completion does not block ready.
// RULE13 - Sleep selected while idle takes effect only after the next conversion completes.
// RULE14 - Software sets sleep first and then starts a conversion to sleep at its end.
// RULE15 - A hardware set beats a software read clear in the same cycle.
// RULE16 - Each end of conversion on an enabled channel sets that channel completion flag.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
module adcrs_flags
    import adcrs_pkg::*;
#(
    parameter int NCH = 8,
    parameter int DW  = 10
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic      [31:0]      avs_readdata,
    output logic                  avs_waitrequest,
    input  wire adcrs_eoc_t       eoc_in,
    output logic                  conv_start,
    output logic      [2:0]       conv_chan,
    output logic                  conv_sleep,
    output logic                  irq
);

    // ------------------------------------------------------------
    // Bus access: one wait cycle, then a single-cycle acknowledge
    // ------------------------------------------------------------
    logic        ack;
    logic        rd_hit;
    logic        wr_hit;
    logic [31:0] next_rdata;

    // Request is accepted at the edge where waitrequest is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    // Waitrequest is registered: low only in the acknowledge cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack & avs_waitrequest);
        end
    end

    assign rd_hit = avs_read & ~avs_waitrequest;
    assign wr_hit = avs_write & ~avs_waitrequest;

    // True when the address is the result register of channel ch
    function automatic logic chan_hit(input logic [7:0] a, input int ch);
        chan_hit = (a == OFS_CHAN0 + 8'(ch * 4));
    endfunction : chan_hit

    // ------------------------------------------------------------
    // Flag state
    // ------------------------------------------------------------
    logic [NCH-1:0] ch_enable;
    logic [NCH-1:0] eoc_flag;
    logic [NCH-1:0] channel_overrun_flag;
    logic           result_ready_flag;
    logic           global_overrun_flag;
    logic [DW-1:0]  channel_result [NCH];
    logic [DW-1:0]  latest_result;
    logic [2:0]     latest_chan;
    logic           sleep_opt;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic [NUM_EVENTS-1:0] event_flag;
    adcrs_state_t   state;

    // Decoded strobes, all qualified by the acknowledge cycle
    logic           rd_status;
    logic           rd_latest;
    logic [NCH-1:0] rd_chan;
    logic           wr_ena;
    logic           wr_dis;
    logic           wr_start;

    assign rd_status = rd_hit & (avs_address == OFS_STATUS);
    assign rd_latest = rd_hit & (avs_address == OFS_LATEST);
    assign wr_ena    = wr_hit & (avs_address == OFS_CH_ENA);
    assign wr_dis    = wr_hit & (avs_address == OFS_CH_DIS);
    assign wr_start  = wr_hit & (avs_address == OFS_CONTROL) & avs_writedata[BIT_START];

    // A result is kept only if its channel is still enabled at completion
    logic eoc_valid;
    logic ovr_new;
    assign eoc_valid = eoc_in.done & ch_enable[eoc_in.chan];  // RULE4 RULE10
    // A new result while ready is still pending is a global overrun
    assign ovr_new   = eoc_valid & result_ready_flag;  // RULE5

    // Read data are taken one edge before the read clears its flags, so a
    // result kept in between was never seen and must survive the clear
    logic kept_late;
    logic rd_latest_ok;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kept_late <= 1'b0;
        end else begin
            kept_late <= eoc_valid;
        end
    end

    assign rd_latest_ok = rd_latest & ~kept_late;  // RULE15

    // Channel enables; disabling one channel never touches another's result path
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_enable <= '0;
        end else begin
            ch_enable <= (ch_enable | (wr_ena ? avs_writedata[NCH-1:0] : '0))
                       & ~(wr_dis ? avs_writedata[NCH-1:0] : '0);
        end
    end

    // ------------------------------------------------------------
    // Per-channel completion, overrun and result store
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            logic hit_eoc;
            logic clr_eoc;
            logic late_set;
            assign hit_eoc = eoc_valid & (eoc_in.chan == 3'(g));
            // Only this channel's own register or the latest register may clear it
            assign clr_eoc = (rd_hit & chan_hit(avs_address, g) & ~late_set)  // RULE11
                           | (rd_latest_ok & (latest_chan == 3'(g)));  // RULE8

            // Completion kept in the wait cycle of a read, after its snapshot
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    late_set <= 1'b0;
                end else begin
                    late_set <= hit_eoc;  // RULE15
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    eoc_flag[g] <= 1'b0;
                end else if (hit_eoc) begin
                    eoc_flag[g] <= 1'b1;  // RULE16 RULE15
                end else if (clr_eoc) begin
                    eoc_flag[g] <= 1'b0;  // RULE8
                end
            end

            // Status read clears only the overrun it reported; a real overrun wins
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    channel_overrun_flag[g] <= 1'b0;
                end else if (hit_eoc & eoc_flag[g] & ~clr_eoc) begin
                    channel_overrun_flag[g] <= 1'b1;  // RULE7 RULE15
                end else if (rd_status & avs_readdata[POS_OVR + g]) begin
                    channel_overrun_flag[g] <= 1'b0;  // RULE9
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    channel_result[g] <= '0;
                end else if (hit_eoc) begin
                    channel_result[g] <= eoc_in.data;  // RULE3
                end
            end
        end
    endgenerate

    // Latest result copy, stored for every kept conversion
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latest_result <= '0;
            latest_chan   <= '0;
        end else if (eoc_valid) begin
            latest_result <= eoc_in.data;  // RULE3
            latest_chan   <= eoc_in.chan;
        end
    end

    // ------------------------------------------------------------
    // Global flags
    // ------------------------------------------------------------
    // Ready depends only on kept results and latest reads, so channel
    // reads and disables elsewhere cannot skip or clear it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_ready_flag <= 1'b0;
        end else if (eoc_valid) begin
            result_ready_flag <= 1'b1;  // RULE3 RULE12 RULE15
        end else if (rd_latest_ok) begin
            result_ready_flag <= 1'b0;  // RULE1 RULE2
        end
    end

    // Overrun set beats the status read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            global_overrun_flag <= 1'b0;
        end else if (ovr_new) begin
            global_overrun_flag <= 1'b1;  // RULE5 RULE15
        end else if (rd_status & avs_readdata[BIT_GOVR]) begin
            global_overrun_flag <= 1'b0;  // RULE6
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencing and sleep
    // ------------------------------------------------------------
    // Sleep is only entered at a completion; selecting it while idle waits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ADCRS_IDLE;
        end else begin
            case (state)
                ADCRS_IDLE: begin
                    if (wr_start) state <= ADCRS_BUSY;
                end
                ADCRS_BUSY: begin
                    if (eoc_in.done) state <= sleep_opt ? ADCRS_SLEEP : ADCRS_IDLE;  // RULE13
                end
                ADCRS_SLEEP: begin
                    if (wr_start) state <= ADCRS_BUSY;
                    else if (!sleep_opt) state <= ADCRS_IDLE;
                end
                default: state <= ADCRS_IDLE;
            endcase
        end
    end

    // Start pulse and channel pick: lowest enabled channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start <= 1'b0;
            conv_chan  <= '0;
        end else begin
            conv_start <= wr_start & (state != ADCRS_BUSY);
            for (int i = NCH - 1; i >= 0; i--) begin
                if (ch_enable[i]) conv_chan <= 3'(i);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_sleep <= 1'b0;
        end else begin
            conv_sleep <= (state == ADCRS_SLEEP);
        end
    end

    // Mode and mask registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_opt <= 1'b0;
            irq_mask  <= '0;
        end else if (wr_hit) begin
            if (avs_address == OFS_MODE) sleep_opt <= avs_writedata[BIT_SLEEP];
            if (avs_address == OFS_IRQ_ENA) irq_mask <= avs_writedata[NUM_EVENTS-1:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupt events: sticky, write one to clear, set wins
    // ------------------------------------------------------------
    logic [NUM_EVENTS-1:0] ev_set;
    logic [NUM_EVENTS-1:0] ev_clr;
    assign ev_set[EV_RDY]  = eoc_valid;
    assign ev_set[EV_GOVR] = ovr_new;
    assign ev_set[EV_OVR]  = eoc_valid & eoc_flag[eoc_in.chan];
    assign ev_clr = (wr_hit & (avs_address == OFS_EVENT)) ? avs_writedata[NUM_EVENTS-1:0] : '0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            event_flag <= '0;
        end else begin
            event_flag <= ev_set | (event_flag & ~ev_clr);  // RULE15
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_flag & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        case (avs_address)
            OFS_MODE:    next_rdata[BIT_SLEEP] = sleep_opt;
            OFS_CH_STAT: next_rdata[NCH-1:0] = ch_enable;
            OFS_STATUS: begin
                next_rdata[POS_EOC +: NCH] = eoc_flag;
                next_rdata[POS_OVR +: NCH] = channel_overrun_flag;
                next_rdata[BIT_RDY]        = result_ready_flag;
                next_rdata[BIT_GOVR]       = global_overrun_flag;
                next_rdata[BIT_SLEEPING]   = (state == ADCRS_SLEEP);
            end
            OFS_LATEST:  next_rdata = {17'h0, 2'h0, latest_chan, latest_result};
            OFS_IRQ_ENA: next_rdata[NUM_EVENTS-1:0] = irq_mask;
            OFS_EVENT:   next_rdata[NUM_EVENTS-1:0] = event_flag;
            OFS_ID:      next_rdata = ID_VALUE;
            default: begin
                for (int i = 0; i < NCH; i++) begin
                    if (chan_hit(avs_address, i)) next_rdata[DW-1:0] = channel_result[i];
                end
            end
        endcase
    end

    // Read data registered at the request edge, valid in the acknowledge cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read & ~ack) begin
            avs_readdata <= next_rdata;
        end
    end

endmodule : adcrs_flags
